// >>> logic/sspc_params.svh
// constants of the synchronous serial port core: register offsets, field positions, resets, codes
// assumes inclusion by bare name from the package and the core
`ifndef SSPC_PARAMS_SVH
`define SSPC_PARAMS_SVH

// register byte offsets on the apb bus
`define SSPC_ADDR_CTRL0 12'h000
`define SSPC_ADDR_CTRL1 12'h004
`define SSPC_ADDR_DATA 12'h008
`define SSPC_ADDR_STATUS 12'h00C
`define SSPC_ADDR_PRESCALE 12'h010
`define SSPC_ADDR_IMASK 12'h014
`define SSPC_ADDR_RIS 12'h018
`define SSPC_ADDR_MIS 12'h01C
`define SSPC_ADDR_ICLR 12'h020
`define SSPC_ADDR_CLKGATE 12'h024

// control zero fields
`define SSPC_F_SIZE_HI 3
`define SSPC_F_SIZE_LO 0
`define SSPC_F_FMT_HI 5
`define SSPC_F_FMT_LO 4
`define SSPC_F_SPO 6
`define SSPC_F_SPH 7
`define SSPC_F_SCR_HI 15
`define SSPC_F_SCR_LO 8

// control one fields
`define SSPC_F_LOOPBACK 0
`define SSPC_F_ENABLE 1
`define SSPC_F_SLAVE 2

// interrupt bit positions in mask, raw, masked and clear registers
`define SSPC_I_OVERRUN 0
`define SSPC_I_TIMEOUT 1
`define SSPC_I_RXSVC 2
`define SSPC_I_TXSVC 3

// status bit positions
`define SSPC_S_TX_EMPTY 0
`define SSPC_S_TX_NOT_FULL 1
`define SSPC_S_RX_NOT_EMPTY 2
`define SSPC_S_RX_FULL 3
`define SSPC_S_BUSY 4

// frame format codes
`define SSPC_FMT_SPI 2'h0
`define SSPC_FMT_SYNC 2'h1
`define SSPC_FMT_CMD 2'h2

// reset values and limits
`define SSPC_RST_CTRL0 16'h0007
`define SSPC_RST_CTRL1 3'h0
`define SSPC_RST_PRESCALE 8'h02
`define SSPC_RST_IMASK 4'h0
`define SSPC_RST_CLKGATE 1'b0
`define SSPC_SIZE_MIN 4'h3
`define SSPC_PRESCALE_MIN 8'h02
`define SSPC_CMD_BITS 5'h08
`define SSPC_SYNC_PULSE_TICKS 6'h01
`define SSPC_CMD_WAIT_TICKS 6'h01
`define SSPC_FIFO_DEPTH 8
`define SSPC_DATA_W 16
`define SSPC_RX_TIMEOUT_CLKS 512

`endif

// >>> logic/sspc_pkg.sv
// types of the synchronous serial port core
// assumes the constant header is on the include path
`include "sspc_params.svh"
package sspc_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_start,
    st_run,
    st_wait,
    st_gap
  } sspc_state_e;
endpackage : sspc_pkg

// >>> logic/sspc_core.sv
// synchronous serial port core: apb registers, fifos, bit-rate divider, master and slave shifter
// assumes one clock pclk; link pins arrive asynchronously and are filtered here
`timescale 1ns/1ps
`include "sspc_params.svh"
module sspc_core #(
  parameter int FIFO_DEPTH = `SSPC_FIFO_DEPTH,
  parameter int PTR_W = 3,
  parameter int RX_TIMEOUT_CLKS = `SSPC_RX_TIMEOUT_CLKS,
  parameter int TMO_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  input wire logic frame_select_pin_i,
  output logic frame_select_pin_o,
  output logic frame_select_pin_oe,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_pin_oe,
  output logic irq,
  output logic irq_tx,
  output logic irq_rx,
  output logic irq_timeout,
  output logic irq_overrun
);

  localparam logic [PTR_W:0] DEPTH_C = (PTR_W+1)'(FIFO_DEPTH);
  localparam logic [PTR_W:0] HALF_C = (PTR_W+1)'(FIFO_DEPTH / 2);
  localparam logic [TMO_W-1:0] TMO_C = TMO_W'(RX_TIMEOUT_CLKS - 1);

  // ==========================================================
  // register file
  logic [15:0] ctrl0_r;
  logic [2:0] ctrl1_r;
  logic [7:0] prescale_r;
  logic [3:0] imask_r;
  logic clkgate_r;
  logic ovr_r;
  logic tmo_r;
  logic [31:0] prdata_r;

  logic setup;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  always_comb
  begin
    case (paddr)
      `SSPC_ADDR_CTRL0, `SSPC_ADDR_CTRL1, `SSPC_ADDR_DATA, `SSPC_ADDR_STATUS, `SSPC_ADDR_PRESCALE,
      `SSPC_ADDR_IMASK, `SSPC_ADDR_RIS, `SSPC_ADDR_MIS, `SSPC_ADDR_ICLR, `SSPC_ADDR_CLKGATE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = prdata_r;

  // decoded fields
  logic [3:0] size;
  logic [1:0] fmt;
  logic [7:0] scr_val;
  logic [7:0] prescale_eff;
  logic spo_eff;
  logic sph_eff;
  logic loopback;
  logic enabled;
  logic slave_mode;
  assign size = (ctrl0_r[`SSPC_F_SIZE_HI:`SSPC_F_SIZE_LO] < `SSPC_SIZE_MIN) ? `SSPC_SIZE_MIN
                : ctrl0_r[`SSPC_F_SIZE_HI:`SSPC_F_SIZE_LO];
  assign fmt = ctrl0_r[`SSPC_F_FMT_HI:`SSPC_F_FMT_LO];
  assign scr_val = ctrl0_r[`SSPC_F_SCR_HI:`SSPC_F_SCR_LO];
  assign prescale_eff = (prescale_r < `SSPC_PRESCALE_MIN) ? `SSPC_PRESCALE_MIN : prescale_r;
  // pulsed-frame and command formats use fixed clock polarity and phase
  assign spo_eff = (fmt == `SSPC_FMT_SPI) ? ctrl0_r[`SSPC_F_SPO] : 1'b0;
  assign sph_eff = (fmt == `SSPC_FMT_SPI) ? ctrl0_r[`SSPC_F_SPH] : (fmt == `SSPC_FMT_SYNC);
  assign loopback = ctrl1_r[`SSPC_F_LOOPBACK];
  assign enabled = ctrl1_r[`SSPC_F_ENABLE] & clkgate_r;
  assign slave_mode = ctrl1_r[`SSPC_F_SLAVE];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl0_r <= `SSPC_RST_CTRL0;
      ctrl1_r <= `SSPC_RST_CTRL1;
      prescale_r <= `SSPC_RST_PRESCALE;
      imask_r <= `SSPC_RST_IMASK;
      clkgate_r <= `SSPC_RST_CLKGATE;
    end
    else if (wr_en)
    begin
      case (paddr)
        `SSPC_ADDR_CTRL0: ctrl0_r <= pwdata[15:0];
        `SSPC_ADDR_CTRL1: ctrl1_r <= pwdata[2:0];
        `SSPC_ADDR_PRESCALE: prescale_r <= {pwdata[7:1], 1'b0};
        `SSPC_ADDR_IMASK: imask_r <= pwdata[3:0];
        `SSPC_ADDR_CLKGATE: clkgate_r <= pwdata[0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // pin synchronisers: three flops, a level counts once stages two and three agree
  logic [2:0] sclk_q;
  logic [2:0] fss_q;
  logic [2:0] rx_q;
  logic s_sclk_r;
  logic s_fss_r;
  logic s_rx_r;
  logic s_sclk_d;
  logic s_fss_d;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_q <= 3'h0;
      fss_q <= 3'h7;
      rx_q <= 3'h0;
      s_sclk_r <= 1'b0;
      s_fss_r <= 1'b1;
      s_rx_r <= 1'b0;
      s_sclk_d <= 1'b0;
      s_fss_d <= 1'b1;
    end
    else
    begin
      sclk_q <= {sclk_q[1:0], serial_clock_pin_i};
      fss_q <= {fss_q[1:0], frame_select_pin_i};
      rx_q <= {rx_q[1:0], serial_in_pin};
      if (sclk_q[1] == sclk_q[2])
        s_sclk_r <= sclk_q[2];
      if (fss_q[1] == fss_q[2])
        s_fss_r <= fss_q[2];
      if (rx_q[1] == rx_q[2])
        s_rx_r <= rx_q[2];
      s_sclk_d <= s_sclk_r;
      s_fss_d <= s_fss_r;
    end
  end

  // ==========================================================
  // fifos
  logic [15:0] tx_mem [FIFO_DEPTH];
  logic [15:0] rx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] tx_wr_r;
  logic [PTR_W-1:0] tx_rd_r;
  logic [PTR_W:0] tx_cnt_r;
  logic [PTR_W-1:0] rx_wr_r;
  logic [PTR_W-1:0] rx_rd_r;
  logic [PTR_W:0] rx_cnt_r;
  logic [PTR_W:0] hist_cnt_r;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_pop;
  logic frame_load;
  logic word_done;
  logic cmd_phase_r;
  logic [15:0] rx_word;
  logic [15:0] load_word;

  assign tx_push = wr_en && paddr == `SSPC_ADDR_DATA && tx_cnt_r != DEPTH_C;
  assign tx_pop = frame_load && tx_cnt_r != '0;
  assign rx_pop = rd_en && paddr == `SSPC_ADDR_DATA && rx_cnt_r != '0;
  assign rx_push = word_done && !cmd_phase_r && rx_cnt_r != DEPTH_C;
  // a popped slot is never cleared, so the write pointer addresses the word written eight pushes ago
  assign load_word = (tx_cnt_r != '0) ? tx_mem[tx_rd_r]
                     : (hist_cnt_r == DEPTH_C) ? tx_mem[tx_wr_r] : 16'h0000;

  always_ff @(posedge pclk)
  begin
    if (tx_push)
      tx_mem[tx_wr_r] <= pwdata[15:0];
    if (rx_push)
      rx_mem[rx_wr_r] <= rx_word;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_wr_r <= '0;
      tx_rd_r <= '0;
      tx_cnt_r <= '0;
      rx_wr_r <= '0;
      rx_rd_r <= '0;
      rx_cnt_r <= '0;
    end
    else
    begin
      if (tx_push)
        tx_wr_r <= tx_wr_r + 1'b1;
      if (tx_pop)
        tx_rd_r <= tx_rd_r + 1'b1;
      tx_cnt_r <= tx_cnt_r + (PTR_W+1)'(tx_push) - (PTR_W+1)'(tx_pop);
      if (rx_push)
        rx_wr_r <= rx_wr_r + 1'b1;
      if (rx_pop)
        rx_rd_r <= rx_rd_r + 1'b1;
      rx_cnt_r <= rx_cnt_r + (PTR_W+1)'(rx_push) - (PTR_W+1)'(rx_pop);
    end
  end

  // writes counted since the module clock gate was switched on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hist_cnt_r <= '0;
    else if (!clkgate_r)
      hist_cnt_r <= '0;
    else if (tx_push && hist_cnt_r != DEPTH_C)
      hist_cnt_r <= hist_cnt_r + 1'b1;
  end

  // ==========================================================
  // bit-rate divider: tick every half serial period = prescale/2 * (1 + rate)
  sspc_pkg::sspc_state_e state_r;
  logic [6:0] pre_cnt_r;
  logic [7:0] scr_cnt_r;
  logic tick;
  logic m_run;
  assign m_run = state_r != sspc_pkg::st_idle;
  assign tick = m_run && pre_cnt_r == prescale_eff[7:1] - 7'h01 && scr_cnt_r == scr_val;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_cnt_r <= '0;
      scr_cnt_r <= '0;
    end
    else if (!m_run)
    begin
      pre_cnt_r <= '0;
      scr_cnt_r <= '0;
    end
    else if (pre_cnt_r == prescale_eff[7:1] - 7'h01)
    begin
      pre_cnt_r <= '0;
      scr_cnt_r <= (scr_cnt_r == scr_val) ? 8'h00 : scr_cnt_r + 8'h01;
    end
    else
      pre_cnt_r <= pre_cnt_r + 7'h01;
  end

  // ==========================================================
  // master frame sequencer
  logic sclk_r;
  logic fss_r;
  logic [5:0] edge_r;
  logic [4:0] nbits;
  logic [5:0] last_edge;
  logic m_go;
  assign nbits = cmd_phase_r ? `SSPC_CMD_BITS : {1'b0, size} + 5'h01;
  assign last_edge = {nbits, 1'b0} - 6'h01;
  assign m_go = enabled && !slave_mode && tx_cnt_r != '0 && state_r == sspc_pkg::st_idle;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= sspc_pkg::st_idle;
      edge_r <= '0;
      sclk_r <= 1'b0;
      fss_r <= 1'b1;
      cmd_phase_r <= 1'b0;
    end
    else if (!enabled || slave_mode)
    begin
      state_r <= sspc_pkg::st_idle;
      edge_r <= '0;
      sclk_r <= spo_eff;
      fss_r <= fmt != `SSPC_FMT_SYNC;
      cmd_phase_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        sspc_pkg::st_idle:
        begin
          sclk_r <= spo_eff;
          fss_r <= fmt != `SSPC_FMT_SYNC;
          if (m_go)
          begin
            state_r <= sspc_pkg::st_start;
            edge_r <= '0;
            cmd_phase_r <= fmt == `SSPC_FMT_CMD;
            fss_r <= fmt == `SSPC_FMT_SYNC;
          end
        end
        sspc_pkg::st_start:
          if (tick)
          begin
            edge_r <= edge_r + 6'h01;
            if (fmt != `SSPC_FMT_SYNC || edge_r == `SSPC_SYNC_PULSE_TICKS)
            begin
              state_r <= sspc_pkg::st_run;
              edge_r <= '0;
              fss_r <= fmt == `SSPC_FMT_SYNC ? 1'b0 : fss_r;
            end
          end
        sspc_pkg::st_run:
          if (tick)
          begin
            sclk_r <= ~sclk_r;
            edge_r <= edge_r + 6'h01;
            if (edge_r == last_edge)
            begin
              edge_r <= '0;
              state_r <= cmd_phase_r ? sspc_pkg::st_wait : sspc_pkg::st_gap;
              fss_r <= cmd_phase_r ? 1'b0 : fmt != `SSPC_FMT_SYNC;
            end
          end
        sspc_pkg::st_wait:
          if (tick)
          begin
            edge_r <= edge_r + 6'h01;
            if (edge_r == `SSPC_CMD_WAIT_TICKS)
            begin
              state_r <= sspc_pkg::st_run;
              edge_r <= '0;
              cmd_phase_r <= 1'b0;
            end
          end
        sspc_pkg::st_gap:
          if (tick)
            state_r <= sspc_pkg::st_idle;
        default: state_r <= sspc_pkg::st_idle;
      endcase
    end
  end

  // ==========================================================
  // shared shift datapath; events come from master ticks or filtered slave clock edges
  logic [15:0] tx_sh_r;
  logic [15:0] rx_sh_r;
  logic [4:0] bit_r;
  logic first_r;
  logic lead_ev;
  logic trail_ev;
  logic sample_ev;
  logic shift_ev;
  logic rx_bit;
  logic slave_on;
  logic fss_fall;
  assign slave_on = enabled && slave_mode;
  assign fss_fall = slave_on && s_fss_d && !s_fss_r;
  always_comb
  begin
    lead_ev = 1'b0;
    trail_ev = 1'b0;
    if (slave_on)
    begin
      lead_ev = !s_fss_r && s_sclk_r != s_sclk_d && s_sclk_d == spo_eff;
      trail_ev = !s_fss_r && s_sclk_r != s_sclk_d && s_sclk_d != spo_eff;
    end
    else if (tick && state_r == sspc_pkg::st_run)
    begin
      lead_ev = sclk_r == spo_eff;
      trail_ev = sclk_r != spo_eff;
    end
  end
  assign sample_ev = sph_eff ? trail_ev : lead_ev;
  assign shift_ev = sph_eff ? lead_ev : trail_ev;
  assign rx_bit = loopback ? tx_sh_r[15] : s_rx_r;
  assign word_done = sample_ev && bit_r == nbits - 5'h01;
  assign rx_word = {rx_sh_r[14:0], rx_bit} & ~(16'hFFFF << nbits);
  // continuous slave frames with phase one keep select low, so the next word loads at the word end
  assign frame_load = (m_go || fss_fall || (slave_on && word_done && sph_eff && !s_fss_r))
                      && !(cmd_phase_r && !m_go);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_sh_r <= '0;
      rx_sh_r <= '0;
      bit_r <= '0;
      first_r <= 1'b0;
    end
    else if (frame_load)
    begin
      tx_sh_r <= (fmt == `SSPC_FMT_CMD) ? {load_word[7:0], 8'h00}
                 : 16'(load_word << (4'hF - size));
      bit_r <= '0;
      first_r <= 1'b1;
    end
    else
    begin
      if (state_r == sspc_pkg::st_wait)
      begin
        tx_sh_r <= '0;
        bit_r <= '0;
      end
      if (sample_ev)
      begin
        rx_sh_r <= {rx_sh_r[14:0], rx_bit};
        bit_r <= word_done ? 5'h00 : bit_r + 5'h01;
      end
      if (shift_ev)
      begin
        first_r <= 1'b0;
        if (!(first_r && sph_eff))
          tx_sh_r <= {tx_sh_r[14:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // interrupt sources
  logic [TMO_W-1:0] tmo_cnt_r;
  logic tmo_hit;
  logic [3:0] ris;
  logic [3:0] mis;
  logic [3:0] iclr;
  assign iclr = (wr_en && paddr == `SSPC_ADDR_ICLR) ? pwdata[3:0] : 4'h0;
  assign tmo_hit = tmo_cnt_r == TMO_C;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tmo_cnt_r <= '0;
    else if (rx_cnt_r == '0 || lead_ev || trail_ev || rx_pop || tmo_hit)
      tmo_cnt_r <= '0;
    else
      tmo_cnt_r <= tmo_cnt_r + 1'b1;
  end
  // sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovr_r <= 1'b0;
      tmo_r <= 1'b0;
    end
    else
    begin
      if (word_done && !cmd_phase_r && rx_cnt_r == DEPTH_C)
        ovr_r <= 1'b1;
      else if (iclr[`SSPC_I_OVERRUN])
        ovr_r <= 1'b0;
      if (tmo_hit)
        tmo_r <= 1'b1;
      else if (iclr[`SSPC_I_TIMEOUT])
        tmo_r <= 1'b0;
    end
  end
  always_comb
  begin
    ris = 4'h0;
    ris[`SSPC_I_OVERRUN] = ovr_r;
    ris[`SSPC_I_TIMEOUT] = tmo_r;
    ris[`SSPC_I_RXSVC] = rx_cnt_r >= HALF_C;
    ris[`SSPC_I_TXSVC] = tx_cnt_r <= HALF_C;
  end
  assign mis = ris & imask_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
      irq_tx <= 1'b0;
      irq_rx <= 1'b0;
      irq_timeout <= 1'b0;
      irq_overrun <= 1'b0;
    end
    else
    begin
      irq <= |mis;
      irq_tx <= mis[`SSPC_I_TXSVC];
      irq_rx <= mis[`SSPC_I_RXSVC];
      irq_timeout <= mis[`SSPC_I_TIMEOUT];
      irq_overrun <= mis[`SSPC_I_OVERRUN];
    end
  end

  // ==========================================================
  // read data captured in the setup phase, valid through the access phase
  logic busy;
  assign busy = m_run || (slave_on && !s_fss_r);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= '0;
    else if (setup && !pwrite)
    begin
      prdata_r <= '0;
      case (paddr)
        `SSPC_ADDR_CTRL0: prdata_r[15:0] <= ctrl0_r;
        `SSPC_ADDR_CTRL1: prdata_r[2:0] <= ctrl1_r;
        `SSPC_ADDR_DATA: prdata_r[15:0] <= (rx_cnt_r != '0) ? rx_mem[rx_rd_r] : 16'h0000;
        `SSPC_ADDR_STATUS:
        begin
          prdata_r[`SSPC_S_TX_EMPTY] <= tx_cnt_r == '0;
          prdata_r[`SSPC_S_TX_NOT_FULL] <= tx_cnt_r != DEPTH_C;
          prdata_r[`SSPC_S_RX_NOT_EMPTY] <= rx_cnt_r != '0;
          prdata_r[`SSPC_S_RX_FULL] <= rx_cnt_r == DEPTH_C;
          prdata_r[`SSPC_S_BUSY] <= busy;
        end
        `SSPC_ADDR_PRESCALE: prdata_r[7:0] <= prescale_r;
        `SSPC_ADDR_IMASK: prdata_r[3:0] <= imask_r;
        `SSPC_ADDR_RIS: prdata_r[3:0] <= ris;
        `SSPC_ADDR_MIS: prdata_r[3:0] <= mis;
        `SSPC_ADDR_CLKGATE: prdata_r[0] <= clkgate_r;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // pins
  assign serial_clock_pin_o = sclk_r;
  assign serial_clock_pin_oe = enabled && !slave_mode;
  assign frame_select_pin_o = fss_r;
  assign frame_select_pin_oe = enabled && !slave_mode;
  assign serial_out_pin = tx_sh_r[15];
  assign serial_out_pin_oe = enabled && !loopback && (slave_mode ? !s_fss_r : m_run);

endmodule : sspc_core

// >>> verification/sspc_core_props.sv
// checker of the core: apb answer, interrupt outputs, pad enables
// assumes a bind onto sspc_core; control bits are mirrored from apb writes
`timescale 1ns/1ps
module sspc_core_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_clock_pin_oe,
  input wire logic frame_select_pin_oe,
  input wire logic serial_out_pin_oe,
  input wire logic irq,
  input wire logic irq_tx,
  input wire logic irq_rx,
  input wire logic irq_timeout,
  input wire logic irq_overrun
);
  logic [2:0] c1_r;
  logic [3:0] im_r;
  logic gt_r;
  logic mst;
  logic lb;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ====
  // mirror of control, mask and gate writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      c1_r <= 3'h0;
      im_r <= 4'h0;
      gt_r <= 1'h0;
    end
    else if (psel && penable && pwrite)
    begin
      if (paddr == 12'h004)
        c1_r <= pwdata[2:0];
      if (paddr == 12'h014)
        im_r <= pwdata[3:0];
      if (paddr == 12'h024)
        gt_r <= pwdata[0];
    end
  end
  assign mst = c1_r[1] && gt_r && !c1_r[2];
  assign lb = c1_r[0];
  sequence s_acc;
    psel && penable;
  endsequence
  // ====
  a_ready_no_wait: assert property (s_acc |-> pready) else $error("pready low in access");
  a_unmapped_err: assert property (s_acc |-> pslverr == (paddr > 12'h024 || paddr[1:0] != 2'h0))
    else $error("pslverr wrong");
  a_irq_or_all: assert property (irq == (irq_tx || irq_rx || irq_timeout || irq_overrun))
    else $error("combined irq differs");
  a_mask_tx_gate: assert property (irq_tx |-> $past(im_r[3])) else $error("tx irq unmasked");
  a_mask_rx_gate: assert property (irq_rx |-> $past(im_r[2])) else $error("rx irq unmasked");
  a_mask_ovr_gate: assert property (irq_overrun |-> $past(im_r[0])) else $error("overrun irq unmasked");
  a_master_clk_oe: assert property (mst && $past(mst) |-> serial_clock_pin_oe)
    else $error("master clock pad off");
  a_slave_clk_off: assert property (!mst && !$past(mst) |-> !serial_clock_pin_oe)
    else $error("clock pad on when not master");
  a_oe_pair_same: assert property (serial_clock_pin_oe == frame_select_pin_oe) else $error("pad enables differ");
  a_loop_quiet: assert property (lb && $past(lb) |-> !serial_out_pin_oe) else $error("out pad on in loopback");
endmodule : sspc_core_props
bind sspc_core sspc_core_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .serial_clock_pin_oe(serial_clock_pin_oe), .frame_select_pin_oe(frame_select_pin_oe),
  .serial_out_pin_oe(serial_out_pin_oe), .irq(irq), .irq_tx(irq_tx), .irq_rx(irq_rx),
  .irq_timeout(irq_timeout), .irq_overrun(irq_overrun));

// >>> verification/sspc_peer_model.sv
// far-side serial peripheral: idle-low clock, samples on rise, shifts on fall
// assumes an active-low select; sends nbits of tx_word msb first
`timescale 1ns/1ps
module sspc_peer_model (
  input wire logic sclk,
  input wire logic fss_n,
  input wire logic mosi,
  input wire logic [15:0] tx_word,
  input wire logic [4:0] nbits,
  output logic miso,
  output logic [15:0] rx_word
);
  logic [15:0] sh_r;
  initial
  begin
    miso = 1'h0;
    rx_word = 16'h0000;
    sh_r = 16'h0000;
  end
  always @(negedge fss_n)
  begin
    sh_r = tx_word << (16 - nbits);
    miso = sh_r[15];
  end
  always @(posedge sclk)
    if (!fss_n)
      rx_word = {rx_word[14:0], mosi};
  always @(negedge sclk)
    if (!fss_n)
    begin
      sh_r = sh_r << 1;
      miso = sh_r[15];
    end
  // a deselected line shows the inverse of its last value
  always @(posedge fss_n)
    miso = ~miso;
endmodule : sspc_peer_model

// >>> verification/test_sync_serial_port_core.sv
// bench of the core: reset values, master frame with peer, loopback fifo traffic
// assumes core, checker and peer model compiled before it
`timescale 1ns/1ps
`include "sspc_params.svh"
module test_sync_serial_port_core;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, err_seen, sclk_o, sclk_oe, fss_o, fss_oe, so, so_oe, miso;
  logic irq, irq_tx, irq_rx, irq_to, irq_ov;
  logic [15:0] peer_rx;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int k;
  logic m_sclk = 1'h0;
  logic m_fss = 1'h1;
  logic [15:0] sw;
  wire logic sclk_w = sclk_oe ? sclk_o : m_sclk;
  wire logic fss_w = fss_oe ? fss_o : m_fss;
  always #10 pclk = ~pclk;
  sspc_core #(.RX_TIMEOUT_CLKS(16)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_pin_i(sclk_w), .serial_clock_pin_o(sclk_o), .serial_clock_pin_oe(sclk_oe),
    .frame_select_pin_i(fss_w), .frame_select_pin_o(fss_o), .frame_select_pin_oe(fss_oe),
    .serial_in_pin(miso), .serial_out_pin(so), .serial_out_pin_oe(so_oe), .irq(irq), .irq_tx(irq_tx),
    .irq_rx(irq_rx), .irq_timeout(irq_to), .irq_overrun(irq_ov));
  sspc_peer_model u_peer (.sclk(sclk_w), .fss_n(fss_w), .mosi(so), .tx_word(16'h003C), .nbits(5'h08),
    .miso(miso), .rx_word(peer_rx));
  // ====
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    err_seen = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, q, e);
  endtask : rc
  task automatic poll(input logic [11:0] a, input int b, input logic v);
    k = 0;
    do
    begin
      apb(1'h0, a, 32'h0);
      k++;
    end
    while (q[b] !== v && k < 300);
    chk("poll", {31'h0, q[b]}, {31'h0, v});
  endtask : poll
  task automatic wait_sclk(input logic v);
    while (sclk_o !== v && k < 500)
    begin
      @(posedge pclk);
      k++;
    end
  endtask : wait_sclk
  // bench as link master: 16 pclk per serial period, spo0 sph0, samples out just before each rise
  task automatic slv(input logic [15:0] e);
    m_fss <= 1'h0;
    for (int b = 0; b < 16; b++)
    begin
      repeat (8) @(posedge pclk);
      sw = {sw[14:0], so};
      m_sclk <= 1'h1;
      repeat (8) @(posedge pclk);
      m_sclk <= 1'h0;
    end
    repeat (8) @(posedge pclk);
    m_fss <= 1'h1;
    repeat (8) @(posedge pclk);
    chk("slave tx", {16'h0, sw}, {16'h0, e});
  endtask : slv
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ====
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rc("ctrl0", `SSPC_ADDR_CTRL0, 32'h7);
    rc("prescale", `SSPC_ADDR_PRESCALE, 32'h2);
    rc("imask", `SSPC_ADDR_IMASK, 32'h0);
    rc("ris", `SSPC_ADDR_RIS, 32'h8);
    rc("mis", `SSPC_ADDR_MIS, 32'h0);
    rc("status", `SSPC_ADDR_STATUS, 32'h3);
    rc("unmapped", 12'h030, 32'h0);
    chk("slverr", {31'h0, err_seen}, 32'h1);
    $display("reset test done");
    apb(1'h1, `SSPC_ADDR_CLKGATE, 32'h1);
    apb(1'h1, `SSPC_ADDR_CTRL0, 32'h0207);
    apb(1'h1, `SSPC_ADDR_PRESCALE, 32'h4);
    apb(1'h1, `SSPC_ADDR_CTRL1, 32'h2);
    apb(1'h1, `SSPC_ADDR_DATA, 32'hA5);
    k = 0;
    wait_sclk(1'h1);
    k = 0;
    wait_sclk(1'h0);
    wait_sclk(1'h1);
    chk("sclk period", k, 32'hC);
    poll(`SSPC_ADDR_STATUS, 4, 1'h0);
    chk("peer rx", {24'h0, peer_rx[7:0]}, 32'hA5);
    rc("rx word", `SSPC_ADDR_DATA, 32'h3C);
    apb(1'h1, `SSPC_ADDR_ICLR, 32'h3);
    rc("ris idle", `SSPC_ADDR_RIS, 32'h8);
    $display("master test done");
    apb(1'h1, `SSPC_ADDR_CTRL1, 32'h0);
    apb(1'h1, `SSPC_ADDR_CTRL0, 32'h000F);
    apb(1'h1, `SSPC_ADDR_PRESCALE, 32'h2);
    apb(1'h1, `SSPC_ADDR_IMASK, 32'h7);
    for (int i = 0; i < 9; i++)
      apb(1'h1, `SSPC_ADDR_DATA, 32'hA000 + i);
    rc("tx full", `SSPC_ADDR_STATUS, 32'h0);
    apb(1'h1, `SSPC_ADDR_CTRL1, 32'h3);
    poll(`SSPC_ADDR_STATUS, 3, 1'h1);
    apb(1'h1, `SSPC_ADDR_DATA, 32'hDEAD);
    poll(`SSPC_ADDR_RIS, 0, 1'h1);
    poll(`SSPC_ADDR_RIS, 1, 1'h1);
    rc("ris", `SSPC_ADDR_RIS, 32'hF);
    rc("mis", `SSPC_ADDR_MIS, 32'h7);
    chk("irq outs", {27'h0, irq, irq_tx, irq_rx, irq_to, irq_ov}, 32'h17);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'h0, `SSPC_ADDR_DATA, 32'h0);
      chk("rx order", q, 32'hA000 + i);
    end
    rc("rx empty", `SSPC_ADDR_DATA, 32'h0);
    apb(1'h1, `SSPC_ADDR_ICLR, 32'h3);
    rc("ris clear", `SSPC_ADDR_RIS, 32'h8);
    chk("irq off", {31'h0, irq}, 32'h0);
    $display("loopback test done");
    apb(1'h1, `SSPC_ADDR_CTRL1, 32'h6);
    slv(16'hA001);
    rc("slave rx", `SSPC_ADDR_DATA, 32'h3C00);
    apb(1'h1, `SSPC_ADDR_CLKGATE, 32'h0);
    apb(1'h1, `SSPC_ADDR_CLKGATE, 32'h1);
    slv(16'h0000);
    rc("slave rx2", `SSPC_ADDR_DATA, 32'h3C00);
    $display("slave test done");
    apb(1'h1, `SSPC_ADDR_CTRL1, 32'h3);
    apb(1'h1, `SSPC_ADDR_CTRL0, 32'h001F);
    apb(1'h1, `SSPC_ADDR_DATA, 32'h5A3C);
    poll(`SSPC_ADDR_STATUS, 2, 1'h1);
    rc("sync word", `SSPC_ADDR_DATA, 32'h5A3C);
    $display("sync test done");
    report_and_stop();
  end
endmodule : test_sync_serial_port_core
